/* File: hw/pis_regs.svh */
// constants of the priority interrupt system
`ifndef PIS_REGS_SVH
`define PIS_REGS_SVH

`define PIS_W            24
`define PIS_NTRAP        8
`define PIS_NLEV         56
`define PIS_IDXW         6
`define PIS_PRIW         7
`define PIS_NONE         7'h38
// installed levels per external group, one bit per level
`define PIS_G1_INSTALLED 24'hffffff
`define PIS_G2_INSTALLED 24'hffffff
// vector words: traps at octal 60, group 1 at octal 70, group 2 at octal 120
`define PIS_VEC_TRAP     16'h0030
`define PIS_VEC_G1       16'h0038
`define PIS_VEC_G2       16'h0050
// forced execute-memory operation code, value is arbitrary
`define PIS_EXM_OPCODE   8'h5a
`define PIS_MODE_BIT     20

`endif

/* File: hw/pis_pkg.sv */
// types of the priority interrupt system
package pis_pkg;
   typedef enum logic [3:0] {
      PIS_OP_WRITE_CTRL_GROUP_ONE    = 4'h0,
      PIS_OP_WRITE_CTRL_GROUP_TWO    = 4'h1,
      PIS_OP_READ_CTRL_GROUP_ONE     = 4'h2,
      PIS_OP_READ_CTRL_GROUP_TWO     = 4'h3,
      PIS_OP_SOFT_TRIGGER_GROUP_ONE  = 4'h4,
      PIS_OP_SOFT_TRIGGER_GROUP_TWO  = 4'h5,
      PIS_OP_READ_REQ_GROUP_ONE      = 4'h6,
      PIS_OP_READ_REQ_GROUP_TWO      = 4'h7,
      PIS_OP_HOLD_EXTERNAL           = 4'h8,
      PIS_OP_RELEASE_EXTERNAL        = 4'h9,
      PIS_OP_SAVE_AND_BRANCH_ENTRY   = 4'ha,
      PIS_OP_RETURN_AND_RESET_LEVEL  = 4'hb,
      PIS_OP_NONE                    = 4'hf
   } pis_op_t;
endpackage

/* File: hw/pis_top.sv */
// priority interrupt system: traps, two external groups, vector entry
`timescale 1ns/100ps
`include "pis_regs.svh"

// What this block does
// - each level has its own vector word: traps 60-67, groups 70-117, 120-147 octal.
// - traps always armed and enabled; external levels need arm and enable.
// - trap goes active on its trigger when no higher level is active.
// - group registers are 8, 16 or 24 bits by installed levels.
// - register bit n belongs to level n of the group.
// - control write copies E to arm mask, A to enable mask.
// - arm one arms, zero disarms; enable one enables, zero inhibits.
// - status reads return masks or request/active without changing them.
// - soft trigger ORs E into request and A into active.
// - a software request bit waits even on a disarmed level, but activates only once the level is armed and enabled.
// - a software active bit activates when no higher level is active.
// - trigger on armed level makes it waiting; disarmed trigger is dropped.
// - waiting inhibited level waits; enabled activates at instruction end unless blocked.
// - inhibited active level is permissive; lower levels may then activate.
// - new trigger at permissive level is kept until it is enabled again.
// - hold blocks activation of all non-active external levels until release.
// - trigger during a protected instruction waits one more instruction.
// - in state zero activation forces an execute-memory of the vector word.
// - the running instruction finishes before entry.
// - save-and-branch puts paging mode in bit 20; return restores it.
// - return-and-reset clears highest non-permissive active level unless held.
// - traps cleared only by return; externals also by control write or clear.
// - priority runs from trap 0 down to group 2 level 23.
module pis_top
   import pis_pkg::*;
(
   // clock and master clear
   input  wire logic                  clk_sys,
   input  wire logic                  resetn,
   // interrupt instructions from the microcode
   input  wire logic                  op_valid,
   input  wire pis_op_t               op_code,
   input  wire logic [`PIS_W-1:0]     e_in,
   input  wire logic [`PIS_W-1:0]     a_in,
   input  wire logic [`PIS_W-1:0]     ret_addr,
   // processor status
   input  wire logic                  instr_done,
   input  wire logic                  instr_protected,
   input  wire logic                  state_zero,
   input  wire logic                  user_mode,
   // trigger sources
   input  wire logic [`PIS_NTRAP-1:0] trap_trig,
   input  wire logic [`PIS_W-1:0]     ext_trig_g1,
   input  wire logic [`PIS_W-1:0]     ext_trig_g2,
   // status read answers
   output logic                       rd_valid,
   output logic [`PIS_W-1:0]          e_out,
   output logic [`PIS_W-1:0]          a_out,
   // interrupt entry and exit
   output logic                       entry_valid,
   output logic [`PIS_W-1:0]          entry_word,
   output logic                       save_valid,
   output logic [`PIS_W-1:0]          save_word,
   output logic                       mode_valid,
   output logic                       mode_user,
   // indicators
   output logic                       int_active,
   output logic                       hold_state
);

   function automatic logic [`PIS_PRIW-1:0] pri_first(input logic [`PIS_NLEV-1:0] v);
      logic [`PIS_PRIW-1:0] r;
      r = `PIS_NONE;
      for (int i = `PIS_NLEV - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = `PIS_PRIW'(i);
         end
      end
      return r;
   endfunction

   function automatic logic [`PIS_NLEV-1:0] one_hot(input logic [`PIS_PRIW-1:0] idx);
      logic [`PIS_NLEV-1:0] r;
      r = '0;
      for (int i = 0; i < `PIS_NLEV; i++) begin
         r[i] = (idx == `PIS_PRIW'(i));
      end
      return r;
   endfunction

   logic [1:0][`PIS_W-1:0]     arm_mask_reg;
   logic [1:0][`PIS_W-1:0]     enable_mask_reg;
   logic [1:0][`PIS_W-1:0]     request_pending_reg;
   logic [1:0][`PIS_W-1:0]     active_levels_reg;
   logic [1:0][`PIS_W-1:0]     force_reg;
   logic [1:0][`PIS_W-1:0]     installed;
   logic [`PIS_NTRAP-1:0]      trap_pend_reg;
   logic [`PIS_NTRAP-1:0]      trap_act_reg;
   logic [1:0][`PIS_W-1:0]     sync1_reg;
   logic [1:0][`PIS_W-1:0]     sync2_reg;
   logic [1:0][`PIS_W-1:0]     sync3_reg;
   logic [1:0][`PIS_W-1:0]     rise;
   logic                       hold_reg;
   logic                       entry_pend_reg;
   logic [`PIS_PRIW-1:0]       entry_idx_reg;
   logic [`PIS_NLEV-1:0]       blk;
   logic [`PIS_NLEV-1:0]       cand;
   logic [`PIS_NLEV-1:0]       act_1h;
   logic [`PIS_NLEV-1:0]       brl_1h;
   logic [`PIS_PRIW-1:0]       hb;
   logic [`PIS_PRIW-1:0]       cidx;
   logic [`PIS_PRIW-1:0]       issue_idx;
   logic                       act_now;
   logic                       ext_go;
   logic                       brl_op;
   logic                       issue;
   logic [1:0]                 wr_ctrl;
   logic [1:0]                 soft_trig;
   logic [1:0][`PIS_W-1:0]     ext_cand;
   logic [`PIS_W-1:0]          vec_addr;

   // bits beyond the installed levels never hold state
   assign installed[0] = `PIS_G1_INSTALLED;
   assign installed[1] = `PIS_G2_INSTALLED;

   assign wr_ctrl[0]   = op_valid && op_code == PIS_OP_WRITE_CTRL_GROUP_ONE;
   assign wr_ctrl[1]   = op_valid && op_code == PIS_OP_WRITE_CTRL_GROUP_TWO;
   assign soft_trig[0] = op_valid && op_code == PIS_OP_SOFT_TRIGGER_GROUP_ONE;
   assign soft_trig[1] = op_valid && op_code == PIS_OP_SOFT_TRIGGER_GROUP_TWO;
   assign brl_op       = op_valid && op_code == PIS_OP_RETURN_AND_RESET_LEVEL;

   // two-stage synchroniser, edge taken between stages two and three
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
         sync3_reg <= '0;
      end else begin
         sync1_reg <= {ext_trig_g2, ext_trig_g1};
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
      end
   end
   assign rise = sync2_reg & ~sync3_reg;

   // no external activation at the end of a protected instruction
   assign ext_go = instr_done && !instr_protected;

   // waiting, armed, enabled, not held; soft active bits bypass masks
   always_comb begin
      for (int g = 0; g < 2; g++) begin
         ext_cand[g] = ((request_pending_reg[g] & arm_mask_reg[g] & enable_mask_reg[g]
                        & ~active_levels_reg[g]) | force_reg[g])
                       & {`PIS_W{ext_go && !hold_reg}};
      end
   end

   // bit n is level n; permissive and not-yet-entered levels do not block
   // soft active bits stay out of blk until entered, else they would mask their own entry
   assign blk  = {active_levels_reg[1] & enable_mask_reg[1] & ~force_reg[1],
                  active_levels_reg[0] & enable_mask_reg[0] & ~force_reg[0],
                  trap_act_reg};
   // traps need no masks and are taken at once
   assign cand = {ext_cand[1], ext_cand[0], trap_pend_reg & ~trap_act_reg};
   assign hb   = pri_first(blk);
   assign cidx = pri_first(cand);
   // only a level above the highest blocking one activates
   assign act_now = cidx < hb;
   assign act_1h  = one_hot(cidx) & {`PIS_NLEV{act_now}};
   // highest non-permissive active level, never while held
   assign brl_1h  = one_hot(hb) & {`PIS_NLEV{brl_op && !hold_reg}};

   // control write loads the masks bit for bit
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         arm_mask_reg    <= '0;
         enable_mask_reg <= '0;
      end else begin
         for (int g = 0; g < 2; g++) begin
            if (wr_ctrl[g]) begin
               arm_mask_reg[g]    <= e_in & installed[g];
               enable_mask_reg[g] <= a_in & installed[g];
            end
         end
      end
   end

   // armed edges and soft bits wait; a new edge beats the clear
   // an edge landing as its level activates is kept, so the level is served again
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         request_pending_reg <= '0;
      end else begin
         for (int g = 0; g < 2; g++) begin
            request_pending_reg[g] <= ((request_pending_reg[g]
                                        & ~act_1h[`PIS_NTRAP + g*`PIS_W +: `PIS_W])
                                       | (rise[g] & arm_mask_reg[g])
                                       | (e_in & {`PIS_W{soft_trig[g]}}))
                                      & installed[g];
         end
      end
   end

   // active set by activation or soft OR; cleared by return or disarm
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         active_levels_reg <= '0;
         force_reg         <= '0;
      end else begin
         for (int g = 0; g < 2; g++) begin
            active_levels_reg[g] <= ((active_levels_reg[g]
                                      & ~brl_1h[`PIS_NTRAP + g*`PIS_W +: `PIS_W]
                                      & ~({`PIS_W{wr_ctrl[g]}} & ~e_in))
                                     | act_1h[`PIS_NTRAP + g*`PIS_W +: `PIS_W]
                                     | (a_in & {`PIS_W{soft_trig[g]}}))
                                    & installed[g];
            force_reg[g] <= ((force_reg[g] & ~act_1h[`PIS_NTRAP + g*`PIS_W +: `PIS_W]
                              & ~brl_1h[`PIS_NTRAP + g*`PIS_W +: `PIS_W])
                             | (a_in & {`PIS_W{soft_trig[g]}})) & installed[g];
         end
      end
   end

   // traps leave the active state only through return-and-reset
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         trap_pend_reg <= '0;
         trap_act_reg  <= '0;
      end else begin
         trap_pend_reg <= (trap_pend_reg & ~act_1h[`PIS_NTRAP-1:0]) | trap_trig;
         trap_act_reg  <= (trap_act_reg & ~brl_1h[`PIS_NTRAP-1:0]) | act_1h[`PIS_NTRAP-1:0];
      end
   end

   // hold set and cleared only by its two instructions
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         hold_reg <= 1'b0;
      end else if (op_valid && op_code == PIS_OP_HOLD_EXTERNAL) begin
         hold_reg <= 1'b1;
      end else if (op_valid && op_code == PIS_OP_RELEASE_EXTERNAL) begin
         hold_reg <= 1'b0;
      end
   end

   // entry waits for the end of an unprotected instruction
   assign issue     = (entry_pend_reg || act_now) && ext_go;
   assign issue_idx = act_now ? cidx : entry_idx_reg;

   // vector words of the three ranges lie back to back
   assign vec_addr = `PIS_W'(`PIS_VEC_TRAP) + `PIS_W'(issue_idx);

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         entry_pend_reg <= 1'b0;
         entry_idx_reg  <= `PIS_NONE;
      end else if (issue) begin
         entry_pend_reg <= 1'b0;
      end else if (act_now) begin
         entry_pend_reg <= 1'b1;
         entry_idx_reg  <= cidx;
      end
   end

   // forced execute-memory word, only in operational state zero
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         entry_valid <= 1'b0;
         entry_word  <= '0;
      end else begin
         entry_valid <= issue && state_zero;
         if (issue && state_zero) begin
            entry_word <= {`PIS_EXM_OPCODE, vec_addr[15:0]};
         end
      end
   end

   // status reads copy without side effects
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         rd_valid <= 1'b0;
         e_out    <= '0;
         a_out    <= '0;
      end else begin
         rd_valid <= 1'b0;
         if (op_valid) begin
            unique case (op_code)
               PIS_OP_READ_CTRL_GROUP_ONE, PIS_OP_READ_CTRL_GROUP_TWO: begin
                  rd_valid <= 1'b1;
                  e_out    <= arm_mask_reg[op_code == PIS_OP_READ_CTRL_GROUP_TWO];
                  a_out    <= enable_mask_reg[op_code == PIS_OP_READ_CTRL_GROUP_TWO];
               end
               PIS_OP_READ_REQ_GROUP_ONE, PIS_OP_READ_REQ_GROUP_TWO: begin
                  rd_valid <= 1'b1;
                  e_out    <= request_pending_reg[op_code == PIS_OP_READ_REQ_GROUP_TWO];
                  a_out    <= active_levels_reg[op_code == PIS_OP_READ_REQ_GROUP_TWO];
               end
               default: begin
               end
            endcase
         end
      end
   end

   // paging mode saved in bit 20 and handed back on return
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         save_valid <= 1'b0;
         save_word  <= '0;
         mode_valid <= 1'b0;
         mode_user  <= 1'b0;
      end else begin
         save_valid <= op_valid && op_code == PIS_OP_SAVE_AND_BRANCH_ENTRY;
         mode_valid <= brl_op;
         if (op_valid && op_code == PIS_OP_SAVE_AND_BRANCH_ENTRY) begin
            save_word <= ret_addr;
            save_word[`PIS_MODE_BIT] <= user_mode;
         end
         if (brl_op) begin
            mode_user <= e_in[`PIS_MODE_BIT];
         end
      end
   end

   // panel lamp: any level active and enabled
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         int_active <= 1'b0;
         hold_state <= 1'b0;
      end else begin
         int_active <= |blk;
         hold_state <= hold_reg;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   a_mask_write: assert property (wr_ctrl[0] |=> arm_mask_reg[0] == $past(e_in))
      else $error("arm mask not loaded from E");
   a_trap_activate: assert property (trap_trig[3] && trap_trig[2:0] == '0
      && trap_pend_reg[2:0] == '0 && blk == '0 |=> ##1 trap_act_reg[3])
      else $error("trap 3 not active two cycles after trigger");
   a_disarm_drop: assert property (rise[1][6] && !arm_mask_reg[1][6]
      && !request_pending_reg[1][6] && !soft_trig[1] |=> !request_pending_reg[1][6])
      else $error("disarmed trigger was kept");
   a_armed_wait: assert property (rise[1][5] && arm_mask_reg[1][5]
      |=> request_pending_reg[1][5])
      else $error("armed trigger not kept waiting");
   a_hold_blocks: assert property (hold_reg && !force_reg[1][5]
      |=> !$rose(active_levels_reg[1][5]) || $past(soft_trig[1]))
      else $error("external level activated while held");
   a_hold_lamp: assert property (op_valid && op_code == PIS_OP_HOLD_EXTERNAL
      |=> ##1 hold_state)
      else $error("hold lamp not lit after hold");
   a_protect_defer: assert property (instr_done && instr_protected |=> !entry_valid)
      else $error("entry at end of protected instruction");
   a_entry_vector: assert property (entry_valid |-> entry_word[15:0] >= 16'h0030
      && entry_word[15:0] <= 16'h0067 && entry_word[23:16] == `PIS_EXM_OPCODE)
      else $error("vector word out of range");
   a_status_stable: assert property (op_valid && op_code == PIS_OP_READ_REQ_GROUP_ONE
      && !soft_trig[0] && !act_now && !brl_op |=> $stable(active_levels_reg[0]))
      else $error("status read changed active register");
   a_soft_active: assert property (soft_trig[1]
      |=> (active_levels_reg[1] & $past(a_in)) == $past(a_in))
      else $error("soft trigger did not set active bits");
   a_ctrl_clear: assert property (wr_ctrl[1] && !act_now
      |=> (active_levels_reg[1] & ~$past(e_in)) == '0)
      else $error("control write kept a disarmed active level");
   a_brl_held: assert property (hold_reg && brl_op
      |=> $past(trap_act_reg) == trap_act_reg || $past(act_now))
      else $error("return cleared a level while held");
   a_save_mode: assert property (op_valid && op_code == PIS_OP_SAVE_AND_BRANCH_ENTRY
      |=> save_valid && save_word[`PIS_MODE_BIT] == $past(user_mode))
      else $error("mode bit not saved");

   c_trap_entry: cover property (trap_trig != '0 ##[1:20] entry_valid);
   c_ext_entry: cover property (rise[1] != '0 ##[1:40] entry_valid);
   c_permissive: cover property (active_levels_reg[1] != '0
      && (active_levels_reg[1] & ~enable_mask_reg[1]) != '0 && act_now);
   c_return: cover property (brl_op && hb != `PIS_NONE);
   c_hold_release: cover property (hold_reg ##1 !hold_reg);

endmodule

/* File: testbench/pis_core_model.sv */
// core model: instruction completion pulses seen by the interrupt block
`timescale 1ns/100ps
module pis_core_model (
   // clock and master clear
   input  wire logic clk_sys,
   input  wire logic resetn,
   // completion kind asked for by the bench
   input  wire logic prot_mode,
   // instruction status towards the block
   output logic      instr_done,
   output logic      instr_protected
);
   logic [2:0] cnt_reg;

   // instructions run whole, one completion every eight cycles
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         cnt_reg <= 3'h0;
      end else begin
         cnt_reg <= cnt_reg + 3'h1;
      end
   end
   assign instr_done = resetn && (cnt_reg == 3'h7);
   // flag only qualifies a completion; it wanders otherwise so nobody relies on it
   assign instr_protected = instr_done ? prot_mode : cnt_reg[0];
endmodule

/* File: testbench/testbench.sv */
// self-checking bench for the priority interrupt block
`timescale 1ns/100ps
module testbench
   import pis_pkg::*;
;
   typedef struct packed {
      pis_op_t     wr;
      pis_op_t     rd;
      logic [23:0] e;
      logic [23:0] a;
   } pis_row_t;
   localparam pis_row_t rows [4] = '{
      '{PIS_OP_WRITE_CTRL_GROUP_ONE, PIS_OP_READ_CTRL_GROUP_ONE, 24'ha5a5a5, 24'h5a5a5a},
      '{PIS_OP_WRITE_CTRL_GROUP_TWO, PIS_OP_READ_CTRL_GROUP_TWO, 24'h123456, 24'hfedcba},
      '{PIS_OP_WRITE_CTRL_GROUP_ONE, PIS_OP_READ_CTRL_GROUP_ONE, 24'hffffff, 24'h000000},
      '{PIS_OP_WRITE_CTRL_GROUP_TWO, PIS_OP_READ_CTRL_GROUP_TWO, 24'h000000, 24'hffffff}};
   // vector bases: octal 60, 70 and 120
   localparam logic [15:0] vec_trap = 16'h0030;
   localparam logic [15:0] vec_g1   = 16'h0038;
   localparam logic [15:0] vec_g2   = 16'h0050;

   logic        clk_sys;
   logic        resetn;
   logic        op_valid;
   pis_op_t     op_code;
   logic [23:0] e_in;
   logic [23:0] a_in;
   logic [23:0] ret_addr;
   logic        instr_done;
   logic        instr_protected;
   logic        state_zero;
   logic        user_mode;
   logic        prot_mode;
   logic [7:0]  trap_trig;
   logic [23:0] ext_trig_g1;
   logic [23:0] ext_trig_g2;
   logic        rd_valid;
   logic [23:0] e_out;
   logic [23:0] a_out;
   logic        entry_valid;
   logic [23:0] entry_word;
   logic        save_valid;
   logic [23:0] save_word;
   logic        mode_valid;
   logic        mode_user;
   logic        int_active;
   logic        hold_state;
   int          fails;
   int          comparisons;

   pis_top i_dut (.clk_sys(clk_sys), .resetn(resetn), .op_valid(op_valid), .op_code(op_code),
      .e_in(e_in), .a_in(a_in), .ret_addr(ret_addr), .instr_done(instr_done),
      .instr_protected(instr_protected), .state_zero(state_zero), .user_mode(user_mode),
      .trap_trig(trap_trig), .ext_trig_g1(ext_trig_g1), .ext_trig_g2(ext_trig_g2),
      .rd_valid(rd_valid), .e_out(e_out), .a_out(a_out), .entry_valid(entry_valid),
      .entry_word(entry_word), .save_valid(save_valid), .save_word(save_word),
      .mode_valid(mode_valid), .mode_user(mode_user), .int_active(int_active),
      .hold_state(hold_state));

   pis_core_model i_core (.clk_sys(clk_sys), .resetn(resetn), .prot_mode(prot_mode),
      .instr_done(instr_done), .instr_protected(instr_protected));

   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic report_and_stop;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // an idle cycle drops a request left standing by do_op
   task automatic step;
      if (op_valid === 1'b1) begin
         op_valid = 1'b0;
      end
      @(posedge clk_sys);
      #1;
   endtask

   // request stays up after its edge, so back-to-back ops never touch op_valid twice
   task automatic do_op(input pis_op_t op, input logic [23:0] e, input logic [23:0] a);
      op_code = op;
      e_in = e;
      a_in = a;
      op_valid = 1'b1;
      @(posedge clk_sys);
      #1;
   endtask

   task automatic rd(input pis_op_t op, input logic [23:0] ee, input logic [23:0] ea);
      do_op(op, 24'h0, 24'h0);
      check({23'h0, rd_valid}, 24'h1);
      check(e_out, ee);
      check(a_out, ea);
   endtask

   // want=0: no entry may appear within lim cycles
   task automatic expect_entry(input logic want, input logic [15:0] vec, input int lim);
      for (int i = 0; i < lim; i++) begin
         if (entry_valid === 1'b1) begin
            check(entry_word, want ? {8'h5a, vec} : 24'hxxxxxx);
            return;
         end
         step;
      end
      check({23'h0, want}, 24'h0);
      if (want) report_and_stop;
   endtask

   task automatic ret_level;
      do_op(PIS_OP_RETURN_AND_RESET_LEVEL, 24'h100000, 24'h0);
      check({23'h0, mode_valid}, 24'h1);
      check({23'h0, mode_user}, 24'h1);
      step;
      check({23'h0, int_active}, 24'h0);
   endtask

   initial begin
      fails = 0;
      comparisons = 0;
      resetn = 1'b0;
      op_valid = 1'b0;
      op_code = PIS_OP_NONE;
      e_in = 24'h0;
      a_in = 24'h0;
      ret_addr = 24'h0;
      state_zero = 1'b1;
      user_mode = 1'b1;
      prot_mode = 1'b0;
      trap_trig = 8'h00;
      ext_trig_g1 = 24'h0;
      ext_trig_g2 = 24'h0;
      repeat (16) step;
      resetn = 1'b1;
      check({22'h0, int_active, hold_state}, 24'h0);
      rd(PIS_OP_READ_CTRL_GROUP_ONE, 24'h0, 24'h0);
      rd(PIS_OP_READ_REQ_GROUP_TWO, 24'h0, 24'h0);
      // read twice: a status read must leave the masks alone
      foreach (rows[i]) begin
         do_op(rows[i].wr, rows[i].e, rows[i].a);
         rd(rows[i].rd, rows[i].e, rows[i].a);
         rd(rows[i].rd, rows[i].e, rows[i].a);
      end
      do_op(PIS_OP_WRITE_CTRL_GROUP_ONE, 24'hffffff, 24'h000000);
      do_op(PIS_OP_SOFT_TRIGGER_GROUP_ONE, 24'h000001, 24'h0);
      do_op(PIS_OP_SOFT_TRIGGER_GROUP_ONE, 24'h000004, 24'h0);
      rd(PIS_OP_READ_REQ_GROUP_ONE, 24'h000005, 24'h0);
      expect_entry(1'b0, 16'h0, 24);
      do_op(PIS_OP_WRITE_CTRL_GROUP_ONE, 24'hffffff, 24'h000004);
      expect_entry(1'b1, vec_g1 + 16'h2, 20);
      ret_addr = 24'h001234;
      do_op(PIS_OP_SAVE_AND_BRANCH_ENTRY, 24'h0, 24'h0);
      check({23'h0, int_active}, 24'h1);
      check({23'h0, save_valid}, 24'h1);
      check(save_word, 24'h101234);
      ret_level;
      do_op(PIS_OP_WRITE_CTRL_GROUP_ONE, 24'hffffff, 24'hffffff);
      expect_entry(1'b1, vec_g1, 20);
      ret_level;
      // hold completions protected so both requests are pending together
      do_op(PIS_OP_WRITE_CTRL_GROUP_TWO, 24'hffffff, 24'hffffff);
      prot_mode = 1'b1;
      do_op(PIS_OP_SOFT_TRIGGER_GROUP_TWO, 24'h000001, 24'h0);
      do_op(PIS_OP_SOFT_TRIGGER_GROUP_ONE, 24'h000010, 24'h0);
      expect_entry(1'b0, 16'h0, 20);
      prot_mode = 1'b0;
      expect_entry(1'b1, vec_g1 + 16'h4, 20);
      ret_level;
      expect_entry(1'b1, vec_g2, 20);
      ret_level;
      do_op(PIS_OP_SOFT_TRIGGER_GROUP_TWO, 24'h0, 24'h000008);
      rd(PIS_OP_READ_REQ_GROUP_TWO, 24'h0, 24'h000008);
      expect_entry(1'b1, vec_g2 + 16'h3, 20);
      ret_level;
      prot_mode = 1'b1;
      trap_trig = 8'h08;
      step;
      trap_trig = 8'h00;
      expect_entry(1'b0, 16'h0, 20);
      prot_mode = 1'b0;
      expect_entry(1'b1, vec_trap + 16'h3, 20);
      ret_level;
      do_op(PIS_OP_WRITE_CTRL_GROUP_TWO, 24'h000000, 24'hffffff);
      ext_trig_g2 = 24'h000040;
      repeat (6) step;
      rd(PIS_OP_READ_REQ_GROUP_TWO, 24'h0, 24'h0);
      ext_trig_g2 = 24'h0;
      do_op(PIS_OP_HOLD_EXTERNAL, 24'h0, 24'h0);
      do_op(PIS_OP_WRITE_CTRL_GROUP_TWO, 24'hffffff, 24'hffffff);
      check({23'h0, hold_state}, 24'h1);
      ext_trig_g2 = 24'h000020;
      expect_entry(1'b0, 16'h0, 30);
      do_op(PIS_OP_RELEASE_EXTERNAL, 24'h0, 24'h0);
      step;
      check({23'h0, hold_state}, 24'h0);
      expect_entry(1'b1, vec_g2 + 16'h5, 20);
      // inhibit active level 5: lower level 6 may then enter
      do_op(PIS_OP_WRITE_CTRL_GROUP_TWO, 24'hffffff, 24'hffffdf);
      do_op(PIS_OP_SOFT_TRIGGER_GROUP_TWO, 24'h000040, 24'h0);
      expect_entry(1'b1, vec_g2 + 16'h6, 20);
      ret_level;
      rd(PIS_OP_READ_REQ_GROUP_TWO, 24'h0, 24'h000020);
      do_op(PIS_OP_WRITE_CTRL_GROUP_TWO, 24'h000000, 24'h000000);
      step;
      check({23'h0, int_active}, 24'h0);
      state_zero = 1'b0;
      trap_trig = 8'h08;
      step;
      trap_trig = 8'h00;
      expect_entry(1'b0, 16'h0, 20);
      state_zero = 1'b1;
      ret_level;
      user_mode = 1'b0;
      do_op(PIS_OP_SAVE_AND_BRANCH_ENTRY, 24'h0, 24'h0);
      check(save_word, 24'h001234);
      do_op(PIS_OP_RETURN_AND_RESET_LEVEL, 24'h0, 24'h0);
      check({23'h0, mode_user}, 24'h0);
      report_and_stop;
   end
endmodule
